// >>> src/sfr_map_pkg.sv
// Purpose: Constants for the special-function register bank.
// Assumes: 8-bit direct register space and a 16-bit external data space.
// Notes: Offsets, field positions and reset values live here only.
package sfr_map_pkg;
    // Direct register addresses.
    localparam logic [7:0] stack_pointer_addr = 8'h81;
    localparam logic [7:0] power_control_addr = 8'h87;
    localparam logic [7:0] timer_control_addr = 8'h88;
    localparam logic [7:0] timer_mode_addr = 8'h89;
    localparam logic [7:0] timer0_low_addr = 8'h8a;
    localparam logic [7:0] timer1_low_addr = 8'h8b;
    localparam logic [7:0] timer0_high_addr = 8'h8c;
    localparam logic [7:0] timer1_high_addr = 8'h8d;
    localparam logic [7:0] timer_aux_mode_addr = 8'h8f;
    localparam logic [7:0] oscillator_trim_addr = 8'h96;
    localparam logic [7:0] serial_control_addr = 8'h98;
    localparam logic [7:0] serial_buffer_addr = 8'h99;
    localparam logic [7:0] watchdog_control_addr = 8'ha7;
    localparam logic [7:0] serial_node_address_addr = 8'ha9;
    localparam logic [7:0] power_control_a_addr = 8'hb5;
    localparam logic [7:0] serial_address_mask_addr = 8'hb9;
    localparam logic [7:0] serial_ext_status_addr = 8'hba;
    localparam logic [7:0] watchdog_load_addr = 8'hc1;
    localparam logic [7:0] watchdog_feed_first_addr = 8'hc2;
    localparam logic [7:0] watchdog_feed_second_addr = 8'hc3;
    localparam logic [7:0] program_status_word_addr = 8'hd0;
    localparam logic [7:0] rtc_control_addr = 8'hd1;
    localparam logic [7:0] rtc_count_high_addr = 8'hd2;
    localparam logic [7:0] rtc_count_low_addr = 8'hd3;
    localparam logic [7:0] two_wire_status_addr = 8'hd9;
    localparam logic [7:0] reset_cause_addr = 8'hdf;
    localparam logic [7:0] port0_input_disable_addr = 8'hf6;
    // Port output mode registers; a write to any of them ends the input-only state.
    localparam logic [7:0] port0_mode_one_addr = 8'h84;
    localparam logic [7:0] port0_mode_two_addr = 8'h85;
    localparam logic [7:0] port1_mode_one_addr = 8'h91;
    localparam logic [7:0] port1_mode_two_addr = 8'h92;
    localparam logic [7:0] port3_mode_one_addr = 8'hb1;
    localparam logic [7:0] port3_mode_two_addr = 8'hb2;
    // Extended registers in the external data space.
    localparam logic [15:0] rtc_data_low_addr = 16'hffbe;
    localparam logic [15:0] rtc_data_high_addr = 16'hffbf;
    localparam logic [15:0] brownout_config_addr = 16'hffc8;
    localparam logic [15:0] clock_control_addr = 16'hffde;
    localparam logic [15:0] ext_window_low = 16'hffbe;
    localparam logic [15:0] ext_window_high = 16'hffde;
    // Writable-bit masks; zero bits are unimplemented, except the watchdog timeout flag, which any control write clears.
    localparam logic [7:0] timer_aux_mode_mask = 8'h11;
    localparam logic [7:0] power_control_a_mask = 8'haa;
    localparam logic [7:0] power_control_mask = 8'hdf;
    localparam logic [7:0] port0_input_disable_mask = 8'h3e;
    localparam logic [7:0] rtc_control_mask = 8'he3;
    localparam logic [7:0] watchdog_control_mask = 8'he5;
    localparam logic [7:0] two_wire_status_mask = 8'hf8;
    localparam logic [7:0] brownout_config_mask = 8'h03;
    localparam logic [7:0] clock_control_mask = 8'h1f;
    localparam logic [7:0] reset_cause_mask = 8'h7f;
    // Reset values.
    localparam logic [7:0] stack_pointer_rst = 8'h07;
    localparam logic [7:0] zero_rst = 8'h00;
    localparam logic [7:0] watchdog_load_rst = 8'hff;
    localparam logic [7:0] rtc_control_rst = 8'h60;
    localparam logic [7:0] watchdog_control_rst = 8'he5;
    localparam logic [7:0] two_wire_status_rst = 8'hf8;
    localparam logic [7:0] reset_cause_power_on = 8'h30;
    // Reset cause field positions.
    localparam int brownout_irq_flag_pos = 6;
    localparam int brownout_reset_flag_pos = 5;
    localparam int power_on_flag_pos = 4;
    localparam int break_reset_flag_pos = 3;
    localparam int watchdog_reset_flag_pos = 2;
    localparam int software_reset_flag_pos = 1;
    localparam int external_reset_flag_pos = 0;
    // Watchdog control field position.
    localparam int watchdog_timeout_flag_pos = 1;
    // Configuration byte positions.
    localparam int cfg1_boi_high_pos = 5;
    localparam int cfg1_boi_low_pos = 3;
    localparam int cfg2_doubler_pos = 7;
    localparam int clock_doubler_pos = 3;
    // Bit-addressable register bases.
    localparam logic [7:0] bit_base_timer_control = 8'h88;
    localparam logic [7:0] bit_base_serial_control = 8'h98;
    localparam logic [7:0] bit_base_status_word = 8'hd0;
endpackage

// >>> src/sfr_map_reset_behaviour.sv
// Purpose: Special-function register bank with per-source reset behaviour.
// Assumes: One clock; reset sources arrive as one-cycle pulses from core logic.
// Notes: Peripheral behaviour behind the registers is outside this block.
`timescale 1ns/1ns

module sfr_map_reset_behaviour #(
    parameter logic [7:0] factory_trim = 8'h80
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic wdt_rst,
    input wire logic bod_rst,
    input wire logic sw_rst,
    input wire logic brk_rst,
    input wire logic ext_rst,
    input wire logic brownout_irq_event,
    input wire logic [7:0] user_config_byte_one,
    input wire logic [7:0] user_config_byte_two,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_op,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_value,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic ext_wr,
    input wire logic ext_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_bit_rdata,
    output logic sfr_hit,
    output logic [7:0] ext_rdata,
    output logic ext_hit,
    output logic port_inputs_only,
    output logic [7:0] timer_control,
    output logic [7:0] power_control_a,
    output logic [7:0] clock_control,
    output logic [7:0] brownout_config
);
    // Any reset source restarts the general registers.
    // Only the power-on and watchdog sources reach the trim, RTC control and count, and watchdog control registers.
    logic any_rst;
    logic keep_rst;
    assign any_rst = sys_rst | por_rst | wdt_rst | bod_rst | sw_rst | brk_rst | ext_rst;
    assign keep_rst = por_rst | wdt_rst;

    logic [7:0] regs_plain [0:13];
    logic [7:0] plain_addr [0:13];
    logic [7:0] plain_mask [0:13];
    logic [7:0] plain_rst [0:13];
    logic [7:0] oscillator_trim;
    logic [7:0] watchdog_control;
    logic [7:0] rtc_control;
    logic [7:0] rtc_count_high;
    logic [7:0] rtc_count_low;
    logic [7:0] reset_cause;
    logic [7:0] two_wire_status;
    logic [7:0] rtc_data_low;
    logic [7:0] rtc_data_high;
    logic [7:0] serial_control;
    logic [7:0] program_status_word;
    logic port_mode_wr;
    logic bit_wr;
    logic [7:0] bit_reg;
    logic [7:0] bit_cur;
    logic [7:0] next_bit_val;

    // Table of plain registers that take their value on any reset.
    assign plain_addr[0] = sfr_map_pkg::stack_pointer_addr;
    assign plain_addr[1] = sfr_map_pkg::power_control_addr;
    assign plain_addr[2] = sfr_map_pkg::timer_mode_addr;
    assign plain_addr[3] = sfr_map_pkg::timer0_low_addr;
    assign plain_addr[4] = sfr_map_pkg::timer1_low_addr;
    assign plain_addr[5] = sfr_map_pkg::timer0_high_addr;
    assign plain_addr[6] = sfr_map_pkg::timer1_high_addr;
    assign plain_addr[7] = sfr_map_pkg::timer_aux_mode_addr;
    assign plain_addr[8] = sfr_map_pkg::serial_node_address_addr;
    assign plain_addr[9] = sfr_map_pkg::serial_address_mask_addr;
    assign plain_addr[10] = sfr_map_pkg::serial_ext_status_addr;
    assign plain_addr[11] = sfr_map_pkg::watchdog_load_addr;
    assign plain_addr[12] = sfr_map_pkg::port0_input_disable_addr;
    assign plain_addr[13] = sfr_map_pkg::serial_buffer_addr;
    assign plain_mask[0] = 8'hff;
    assign plain_mask[1] = sfr_map_pkg::power_control_mask;
    assign plain_mask[2] = 8'hff;
    assign plain_mask[3] = 8'hff;
    assign plain_mask[4] = 8'hff;
    assign plain_mask[5] = 8'hff;
    assign plain_mask[6] = 8'hff;
    assign plain_mask[7] = sfr_map_pkg::timer_aux_mode_mask;
    assign plain_mask[8] = 8'hff;
    assign plain_mask[9] = 8'hff;
    assign plain_mask[10] = 8'hff;
    assign plain_mask[11] = 8'hff;
    assign plain_mask[12] = sfr_map_pkg::port0_input_disable_mask;
    assign plain_mask[13] = 8'hff;
    // Every entry gets a defined reset; the serial buffer has no fixed one, so zero is used.
    assign plain_rst[0] = sfr_map_pkg::stack_pointer_rst;
    assign plain_rst[1] = sfr_map_pkg::zero_rst;
    assign plain_rst[2] = sfr_map_pkg::zero_rst;
    assign plain_rst[3] = sfr_map_pkg::zero_rst;
    assign plain_rst[4] = sfr_map_pkg::zero_rst;
    assign plain_rst[5] = sfr_map_pkg::zero_rst;
    assign plain_rst[6] = sfr_map_pkg::zero_rst;
    assign plain_rst[7] = sfr_map_pkg::zero_rst;
    assign plain_rst[8] = sfr_map_pkg::zero_rst;
    assign plain_rst[9] = sfr_map_pkg::zero_rst;
    assign plain_rst[10] = sfr_map_pkg::zero_rst;
    assign plain_rst[11] = sfr_map_pkg::watchdog_load_rst;
    assign plain_rst[12] = sfr_map_pkg::zero_rst;
    assign plain_rst[13] = sfr_map_pkg::zero_rst;

    // Bit operations touch only the three bit-addressable registers.
    always_comb begin
        bit_wr = 1'b0;
        bit_reg = 8'h00;
        if (sfr_bit_op) begin
            case (sfr_bit_addr[7:3])
                sfr_map_pkg::bit_base_timer_control[7:3]: begin
                    bit_reg = sfr_map_pkg::timer_control_addr;
                end
                sfr_map_pkg::bit_base_serial_control[7:3]: begin
                    bit_reg = sfr_map_pkg::serial_control_addr;
                end
                sfr_map_pkg::bit_base_status_word[7:3]: begin
                    bit_reg = sfr_map_pkg::program_status_word_addr;
                end
                default: begin
                    bit_reg = 8'h00;
                end
            endcase
            bit_wr = sfr_wr && (bit_reg != 8'h00);
        end
    end

    // Read-modify-write value for a single bit.
    always_comb begin
        bit_cur = 8'h00;
        case (bit_reg)
            sfr_map_pkg::timer_control_addr: bit_cur = timer_control;
            sfr_map_pkg::serial_control_addr: bit_cur = serial_control;
            sfr_map_pkg::program_status_word_addr: bit_cur = program_status_word;
            default: bit_cur = 8'h00;
        endcase
        next_bit_val = bit_cur;
        next_bit_val[sfr_bit_addr[2:0]] = sfr_bit_value;
    end

    // Plain registers; unimplemented bits never store a one.
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi++) begin : g_plain
            always_ff @(posedge ref_clk) begin
                if (any_rst) begin
                    regs_plain[gi] <= plain_rst[gi];
                end else if (sfr_wr && !sfr_bit_op && sfr_addr == plain_addr[gi]) begin
                    regs_plain[gi] <= sfr_wdata & plain_mask[gi];
                end
            end
        end
    endgenerate

    // Bit-addressable registers accept byte and single-bit writes.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            timer_control <= sfr_map_pkg::zero_rst;
            serial_control <= sfr_map_pkg::zero_rst;
            program_status_word <= sfr_map_pkg::zero_rst;
        end else if (bit_wr) begin
            if (bit_reg == sfr_map_pkg::timer_control_addr) timer_control <= next_bit_val;
            if (bit_reg == sfr_map_pkg::serial_control_addr) serial_control <= next_bit_val;
            if (bit_reg == sfr_map_pkg::program_status_word_addr) begin
                program_status_word <= next_bit_val;
            end
        end else if (sfr_wr && !sfr_bit_op) begin
            if (sfr_addr == sfr_map_pkg::timer_control_addr) timer_control <= sfr_wdata;
            if (sfr_addr == sfr_map_pkg::serial_control_addr) serial_control <= sfr_wdata;
            if (sfr_addr == sfr_map_pkg::program_status_word_addr) begin
                program_status_word <= sfr_wdata;
            end
        end
    end

    // Power control A and two-wire status reset on any source.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            power_control_a <= sfr_map_pkg::zero_rst;
            two_wire_status <= sfr_map_pkg::two_wire_status_rst;
        end else if (sfr_wr && !sfr_bit_op) begin
            if (sfr_addr == sfr_map_pkg::power_control_a_addr) begin
                power_control_a <= sfr_wdata & sfr_map_pkg::power_control_a_mask;
            end
            if (sfr_addr == sfr_map_pkg::two_wire_status_addr) begin
                two_wire_status <= sfr_wdata & sfr_map_pkg::two_wire_status_mask;
            end
        end
    end

    // Registers that survive every reset except power-on and watchdog.
    always_ff @(posedge ref_clk) begin
        if (keep_rst) begin
            oscillator_trim <= factory_trim;
            rtc_control <= sfr_map_pkg::rtc_control_rst;
            rtc_count_high <= sfr_map_pkg::zero_rst;
            rtc_count_low <= sfr_map_pkg::zero_rst;
        end else if (sfr_wr && !sfr_bit_op) begin
            if (sfr_addr == sfr_map_pkg::oscillator_trim_addr) oscillator_trim <= sfr_wdata;
            if (sfr_addr == sfr_map_pkg::rtc_control_addr) begin
                rtc_control <= sfr_wdata & sfr_map_pkg::rtc_control_mask;
            end
            if (sfr_addr == sfr_map_pkg::rtc_count_high_addr) rtc_count_high <= sfr_wdata;
            if (sfr_addr == sfr_map_pkg::rtc_count_low_addr) rtc_count_low <= sfr_wdata;
        end
    end

    // Watchdog control: timeout flag follows the reset source that fired.
    always_ff @(posedge ref_clk) begin
        if (keep_rst) begin
            // The later bit assignment wins; power-on beats a coincident watchdog reset.
            watchdog_control <= sfr_map_pkg::watchdog_control_rst;
            watchdog_control[sfr_map_pkg::watchdog_timeout_flag_pos] <=
                wdt_rst && !por_rst;
        end else if (sfr_wr && !sfr_bit_op && sfr_addr == sfr_map_pkg::watchdog_control_addr) begin
            watchdog_control <= sfr_wdata & sfr_map_pkg::watchdog_control_mask;
        end
    end

    // Reset cause: power-on overrides; other sources set their own flag.
    // A brown-out irq event wins over a same-cycle software clear of that flag.
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            reset_cause <= sfr_map_pkg::reset_cause_power_on;
        end else begin
            if (sfr_wr && !sfr_bit_op && sfr_addr == sfr_map_pkg::reset_cause_addr) begin
                reset_cause <= reset_cause & sfr_wdata & sfr_map_pkg::reset_cause_mask;
            end
            if (bod_rst) reset_cause[sfr_map_pkg::brownout_reset_flag_pos] <= 1'b1;
            if (brk_rst) reset_cause[sfr_map_pkg::break_reset_flag_pos] <= 1'b1;
            if (wdt_rst) reset_cause[sfr_map_pkg::watchdog_reset_flag_pos] <= 1'b1;
            if (sw_rst) reset_cause[sfr_map_pkg::software_reset_flag_pos] <= 1'b1;
            if (ext_rst) reset_cause[sfr_map_pkg::external_reset_flag_pos] <= 1'b1;
            if (brownout_irq_event) begin
                reset_cause[sfr_map_pkg::brownout_irq_flag_pos] <= 1'b1;
            end
        end
    end

    // Extended registers: configuration bits come from the user bytes.
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            brownout_config <= {6'h00, user_config_byte_one[sfr_map_pkg::cfg1_boi_high_pos],
                user_config_byte_one[sfr_map_pkg::cfg1_boi_low_pos]};
        end else if (ext_wr && ext_addr == sfr_map_pkg::brownout_config_addr) begin
            brownout_config <= ext_wdata & sfr_map_pkg::brownout_config_mask;
        end
    end

    // Clock control reloads its select bits from the user bytes on any reset.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            clock_control <= {4'h0, user_config_byte_two[sfr_map_pkg::cfg2_doubler_pos],
                user_config_byte_one[2:0]};
            rtc_data_low <= sfr_map_pkg::zero_rst;
            rtc_data_high <= sfr_map_pkg::zero_rst;
        end else if (ext_wr) begin
            if (ext_addr == sfr_map_pkg::clock_control_addr) begin
                clock_control <= ext_wdata & sfr_map_pkg::clock_control_mask;
            end
            if (ext_addr == sfr_map_pkg::rtc_data_low_addr) rtc_data_low <= ext_wdata;
            if (ext_addr == sfr_map_pkg::rtc_data_high_addr) rtc_data_high <= ext_wdata;
        end
    end

    // A byte write to a port output mode register ends the power-up input-only state.
    // Neighbours such as power control must not match, or pins would drive too early.
    assign port_mode_wr = sfr_wr && !sfr_bit_op &&
        (sfr_addr == sfr_map_pkg::port0_mode_one_addr ||
        sfr_addr == sfr_map_pkg::port0_mode_two_addr ||
        sfr_addr == sfr_map_pkg::port1_mode_one_addr ||
        sfr_addr == sfr_map_pkg::port1_mode_two_addr ||
        sfr_addr == sfr_map_pkg::port3_mode_one_addr ||
        sfr_addr == sfr_map_pkg::port3_mode_two_addr);

    // Ports stay input-only until software writes a port mode register.
    always_ff @(posedge ref_clk) begin
        if (por_rst || sys_rst) begin
            port_inputs_only <= 1'b1;
        end else if (port_mode_wr) begin
            port_inputs_only <= 1'b0;
        end
    end

    // Direct-space read mux; feed registers are write-only and read zero.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
            sfr_bit_rdata <= 1'b0;
        end else begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
            sfr_bit_rdata <= bit_cur[sfr_bit_addr[2:0]];
            if (sfr_rd) begin
                sfr_hit <= 1'b1;
                case (sfr_addr)
                    sfr_map_pkg::timer_control_addr: sfr_rdata <= timer_control;
                    sfr_map_pkg::serial_control_addr: sfr_rdata <= serial_control;
                    sfr_map_pkg::program_status_word_addr: sfr_rdata <= program_status_word;
                    sfr_map_pkg::power_control_a_addr: sfr_rdata <= power_control_a;
                    sfr_map_pkg::two_wire_status_addr: sfr_rdata <= two_wire_status;
                    sfr_map_pkg::oscillator_trim_addr: sfr_rdata <= oscillator_trim;
                    sfr_map_pkg::watchdog_control_addr: sfr_rdata <= watchdog_control;
                    sfr_map_pkg::rtc_control_addr: sfr_rdata <= rtc_control;
                    sfr_map_pkg::rtc_count_high_addr: sfr_rdata <= rtc_count_high;
                    sfr_map_pkg::rtc_count_low_addr: sfr_rdata <= rtc_count_low;
                    sfr_map_pkg::reset_cause_addr: sfr_rdata <= reset_cause;
                    sfr_map_pkg::watchdog_feed_first_addr: sfr_rdata <= 8'h00;
                    sfr_map_pkg::watchdog_feed_second_addr: sfr_rdata <= 8'h00;
                    default: begin
                        // Table lookup; an unmapped address reads zero with no hit.
                        sfr_hit <= 1'b0;
                        for (int i = 0; i < 14; i++) begin
                            if (sfr_addr == plain_addr[i]) begin
                                sfr_rdata <= regs_plain[i];
                                sfr_hit <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Extended read mux answers only inside its own window.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            ext_rdata <= 8'h00;
            ext_hit <= 1'b0;
        end else begin
            ext_rdata <= 8'h00;
            ext_hit <= ext_rd && ext_addr >= sfr_map_pkg::ext_window_low &&
                ext_addr <= sfr_map_pkg::ext_window_high;
            if (ext_rd) begin
                case (ext_addr)
                    sfr_map_pkg::rtc_data_low_addr: ext_rdata <= rtc_data_low;
                    sfr_map_pkg::rtc_data_high_addr: ext_rdata <= rtc_data_high;
                    sfr_map_pkg::brownout_config_addr: ext_rdata <= brownout_config;
                    sfr_map_pkg::clock_control_addr: ext_rdata <= clock_control;
                    default: ext_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // sfr_map_reset_behaviour

// >>> tb/sfr_map_reset_behaviour_asserts.sv
// Purpose: Port-level checks of the register bank.
// Assumes: Sees only the bank's ports; one clock, synchronous reset.
// Notes: Reset-source checks lean on the power-on input, the widest reset.
`timescale 1ns/1ns
module sfr_map_reset_behaviour_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic ext_rst,
    input wire logic ext_rd,
    input wire logic ext_hit,
    input wire logic port_inputs_only,
    input wire logic [7:0] user_config_byte_one,
    input wire logic [7:0] user_config_byte_two,
    input wire logic [7:0] timer_control,
    input wire logic [7:0] power_control_a,
    input wire logic [7:0] clock_control,
    input wire logic [7:0] brownout_config,
    input wire logic [15:0] ext_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // A read that lands inside the extended window.
    sequence s_ext_in; ext_rd && ext_addr >= 16'hffbe && ext_addr <= 16'hffde; endsequence
    // Window decode, masked bits, and power-on and external-reset loads, each tied to its cause.
    chk_ext_in: assert property (s_ext_in |=> ext_hit) else $error("ext hit missing");
    chk_ext_out: assert property (ext_rd && !(ext_addr inside {[16'hffbe:16'hffde]})
        |=> !ext_hit) else $error("ext hit outside");
    chk_ext_cause: assert property (ext_hit |-> $past(ext_rd)) else $error("ext hit");
    chk_pwr_a_bits: assert property ((power_control_a & 8'h55) == 8'h00)
        else $error("unimplemented power control A bit set");
    chk_pwr_a_por: assert property (por_rst |=> power_control_a == 8'h00)
        else $error("power control A not cleared by power-on");
    chk_timer_ctl_por: assert property (por_rst |=> timer_control == 8'h00)
        else $error("timer control not cleared by power-on");
    chk_timer_ctl_ext: assert property (ext_rst |=> timer_control == 8'h00)
        else $error("timer control not cleared by external reset");
    chk_osc_sel: assert property (por_rst |=> clock_control ==
        {4'h0, $past(user_config_byte_two[7]), $past(user_config_byte_one[2:0])})
        else $error("clock control not loaded from config bytes");
    chk_ports_por: assert property (por_rst |=> port_inputs_only [*2]) else $error("ports");
    chk_boi_copy: assert property (por_rst |=> brownout_config ==
        {6'h00, $past(user_config_byte_one[5]), $past(user_config_byte_one[3])})
        else $error("boi cfg");
endmodule // sfr_map_reset_behaviour_asserts
bind sfr_map_reset_behaviour sfr_map_reset_behaviour_asserts u_chk (.*);

// >>> tb/sfr_core_model.sv
// Purpose: Processor core model issuing register and external-space requests.
// Assumes: One request per call, held across exactly one clock edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ns
module sfr_core_model (
    input wire logic ref_clk,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic sfr_bit_op,
    output logic sfr_bit_value,
    output logic ext_wr,
    output logic ext_rd,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_bit_addr,
    output logic [7:0] sfr_wdata,
    output logic [7:0] ext_wdata,
    output logic [15:0] ext_addr
);
    logic [53:0] bus = 54'h0;
    // Strobes lead the vector as {ext_wr, ext_rd, bit_op, wr, rd}.
    assign {ext_wr, ext_rd, sfr_bit_op, sfr_wr, sfr_rd, sfr_addr, sfr_bit_addr,
        ext_addr, sfr_wdata, ext_wdata, sfr_bit_value} = bus;
    // Extended registers are only reached with the external strobes.
    task automatic access(input logic [4:0] s, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk) #10 bus = {s, a[7:0], a[7:0], a, d, d, d[0]};
        @(posedge ref_clk) #10 bus = {5'h00, ~bus[48:0]};
    endtask
endmodule // sfr_core_model

// >>> tb/tb_sfr_map_reset_behaviour.sv
// Purpose: Self-checking bench for the register bank and its reset sources.
// Assumes: The core model issues every bus request; reset sources pulse one cycle.
// Notes: Trim is overridden so a register that never loads cannot pass.
`timescale 1ns/1ns
module tb_sfr_map_reset_behaviour;
    logic ref_clk = 1'b0, sys_rst = 1'b1, brownout_irq_event = 1'b0, ext_rst = 1'b0;
    logic por_rst = 1'b0, wdt_rst = 1'b0, bod_rst = 1'b0, sw_rst = 1'b0, brk_rst = 1'b0;
    logic [7:0] user_config_byte_one = 8'h22, user_config_byte_two = 8'h80;
    wire logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, ext_wdata, sfr_rdata, ext_rdata;
    wire logic [7:0] timer_control, power_control_a, clock_control, brownout_config;
    wire logic [15:0] ext_addr;
    wire logic sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_value, ext_wr, ext_rd;
    wire logic ext_hit, sfr_hit, sfr_bit_rdata, port_inputs_only;
    int mismatches = 0, total_checks = 0;
    // Bank with a non-default trim; the core model drives its bus.
    sfr_map_reset_behaviour #(.factory_trim(8'h5a)) u_dut (.*);
    sfr_core_model u_core (.*);
    // Clock of 100 ns period.
    always #50 ref_clk = ~ref_clk;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) mismatches++;
        if (seen !== exp) $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        logic hit_exp;
        hit_exp = !a[15] || (a >= 16'hffbe && a <= 16'hffde);
        u_core.access(a[15] ? 5'h08 : 5'h01, a, 8'h00);
        check($sformatf("reg %h", a), a[15] ? ext_rdata : sfr_rdata, exp);
        check($sformatf("hit %h", a), {7'h00, a[15] ? ext_hit : sfr_hit}, {7'h00, hit_exp});
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge ref_clk) #10 {por_rst, wdt_rst, bod_rst, sw_rst, brk_rst, ext_rst} = v;
        @(posedge ref_clk) #10 {por_rst, wdt_rst, bod_rst, sw_rst, brk_rst, ext_rst} = 6'h00;
    endtask
    // Power-on, then software, watchdog and brown-out sources in turn.
    task automatic t_sources;
        pulse(6'h20);
        check("osc sel", {4'h0, clock_control[3:0]}, 8'h0a);
        check("brownout cfg", brownout_config, 8'h02);
        rd(16'h00df, 8'h30);
        rd(16'h00a7, 8'he5);
        u_core.access(5'h02, 16'h00df, 8'h00);
        u_core.access(5'h02, 16'h0096, 8'h33);
        pulse(6'h04);
        rd(16'h00df, 8'h02);
        rd(16'h0096, 8'h33);
        pulse(6'h10);
        rd(16'h0096, 8'h5a);
        pulse(6'h08);
        rd(16'h00a7, 8'he7);
        @(posedge ref_clk) #10 brownout_irq_event = 1'b1;
        @(posedge ref_clk) #10 brownout_irq_event = 1'b0;
        rd(16'h00df, 8'h66);
        rd(16'h00d9, 8'hf8);
    endtask
    // Bit writes, unimplemented bits, the extended window and an external reset.
    task automatic t_map;
        u_core.access(5'h06, 16'h008c, 8'h01);
        check("timer control", timer_control, 8'h10);
        u_core.access(5'h05, 16'h008c, 8'h00);
        check("bit read", {7'h00, sfr_bit_rdata}, 8'h01);
        u_core.access(5'h02, 16'h008f, 8'hff);
        rd(16'h008f, 8'h11);
        u_core.access(5'h02, 16'h00b5, 8'hff);
        check("power control a", power_control_a, 8'haa);
        u_core.access(5'h02, 16'h0087, 8'hff);
        rd(16'h0087, 8'hdf);
        check("inputs only", {7'h00, port_inputs_only}, 8'h01);
        u_core.access(5'h02, 16'h0084, 8'h00);
        check("inputs only", {7'h00, port_inputs_only}, 8'h00);
        u_core.access(5'h10, 16'hffbf, 8'ha5);
        rd(16'hffbf, 8'ha5);
        rd(16'hffdf, 8'h00);
        pulse(6'h01);
        check("timer control", timer_control, 8'h00);
    endtask
    task automatic final_report;
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Hold reset two cycles, run the scenarios, then report.
    initial begin
        repeat (2) @(posedge ref_clk);
        #10 sys_rst = 1'b0;
        t_sources();
        t_map();
        final_report();
    end
endmodule // tb_sfr_map_reset_behaviour
